// [design/msa_top.sv]
`timescale 1ns/1ps

// Summary of operation
// - Watched run line low halts measurement.
// - Driven run line: release on start, pull on halt.
// - Software enables, disables, forces the run line.
// - Eight I/O bits: input, open-drain, driven; readback.
// - 250 ps stamps, 38-bit timer, low 32 sent.
// - Timer bits 5..31 offered as selectable taps.
// - Armed: trigger starts timer, stops stamped.
// - Range elapsed ends sweep; short dead time.
// - Triggers ignored until hold-off elapses.
// - Stops before acquisition delay are discarded.
// - Stops outside window never reach buffers.
// - Continuous mode: no dead time, timer wraps.
// - Sequential: drain, close, restart same count.
// - Marker word inserted per accepted trigger.
// - Tags sampled 110 ns (22 cycles) after each stop.
// - Tags replace upper eight event bits.
// - First buffer holds 127 entries.
// - First buffer moves into 16k second buffer.
// - Both buffer full conditions flagged and output.
// - Sweep counter counts sweep starts.
// - Preset reached blocks further sweeps.
// - Without preset, sweep counter starts at zero.
// - Sweep-active output high while sweep runs.
module msa_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic trigger_in,
  input wire logic stop_in,
  input wire logic [7:0] tag_in,
  input wire logic go_in,
  output logic go_out,
  output logic go_oe_out,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic [7:0] io_oe_out,
  output logic [26:0] tap_out,
  output logic sync_out,
  output logic sweep_active_out,
  output logic fast_buffer_full_out,
  output logic bulk_buffer_full_out,
  output logic seq_done_out,
  output logic [31:0] evt_data_out,
  output logic evt_valid_out,
  input wire logic evt_ready_in
);

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {IDLE, ARMED, SWEEP, DEAD, DRAIN} msa_st_t;
  msa_st_t st_q; // Sequencer state.
  msa_pkg::msa_ctrl_t ctrl_q; // Control register.
  logic [31:0] range_q, delay_q, holdoff_q, preset_q; // Settings.
  logic [31:0] sweep_q; // Sweep counter.
  logic [15:0] io_mode_q; // Two bits per I/O line.
  logic [7:0] io_val_q; // I/O output values.
  logic [4:0] tap_sel_q; // Tap selected for sync_out.
  logic run_q; // Measurement running.
  logic fast_ovf_q, bulk_ovf_q; // Sticky overflow flags.
  logic [37:0] timer_q; // Timer in 250 ps bins.
  logic [37:0] hold_q; // Hold-off elapsed time in bins.
  logic [7:0] dead_q; // Dead-time counter.
  logic seq_q; // Sequence close pulse.
  logic ap_wr_q; // Pending write data phase.
  logic [7:0] ap_addr_q; // Address of pending write.
  logic [31:0] rdata_q; // Read data for the data phase.
  logic [2:0] trg_s, stp_s; // Trigger and stop sync plus edge.
  logic [1:0] go_s; // Run line synchroniser.
  logic [2:0] run_sr_q; // Run history; masks our own pull still in sync.
  logic [7:0] tag_s1, tag_s2, io_s1, io_s2; // Bus synchronisers.
  msa_pkg::msa_evt_t dly_q [msa_pkg::TAG_DLY_CYC]; // Stop delay line.
  logic [31:0] fast_mem [msa_pkg::FAST_DEPTH]; // First buffer.
  logic [6:0] f_wr_q, f_rd_q; // First buffer pointers.
  logic [7:0] f_cnt_q; // First buffer fill.
  logic [31:0] bulk_mem [msa_pkg::BULK_DEPTH]; // Second buffer.
  logic [13:0] b_wr_q, b_rd_q; // Second buffer pointers.
  logic [14:0] b_cnt_q; // Second buffer fill.
  logic [31:0] out_q; // Output data word.
  logic out_v_q; // Output word valid.
  logic wr_en, wr_ctrl, wr_status, trig, stop_ev, go_low, halt;
  logic can_start, accept_trg, in_window, sweep_end, active;
  logic f_full, f_empty, b_full, b_empty, f_push, fwd, b_pop;
  logic [31:0] f_word, ev_word, status_w;
  logic [31:0] sweep_init;

  // -------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------
  // Pins pass two flops; a third flop of trigger/stop finds edges.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      trg_s <= 3'h0;
      stp_s <= 3'h0;
      go_s <= 2'h3;
      run_sr_q <= 3'h0;
      tag_s1 <= 8'h00;
      tag_s2 <= 8'h00;
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
    end else begin
      trg_s <= {trg_s[1:0], trigger_in};
      stp_s <= {stp_s[1:0], stop_in};
      go_s <= {go_s[0], go_in};
      run_sr_q <= {run_sr_q[1:0], run_q};
      tag_s1 <= tag_in;
      tag_s2 <= tag_s1;
      io_s1 <= io_in;
      io_s2 <= io_s1;
    end
  end
  assign trig = trg_s[1] & ~trg_s[2];
  assign stop_ev = stp_s[1] & ~stp_s[2];

  // -------------------------------------------------------------------
  // AHB-Lite slave
  // -------------------------------------------------------------------
  assign wr_en = ap_wr_q;
  assign wr_ctrl = wr_en && ap_addr_q == msa_pkg::REG_CTRL;
  assign wr_status = wr_en && ap_addr_q == msa_pkg::REG_STATUS;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_q;

  // Status word: live levels plus sticky flags.
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[msa_pkg::ST_RUN] = run_q;
    status_w[msa_pkg::ST_ACTIVE] = active;
    status_w[msa_pkg::ST_FAST_FULL] = f_full;
    status_w[msa_pkg::ST_BULK_FULL] = b_full;
    status_w[msa_pkg::ST_FAST_OVF] = fast_ovf_q;
    status_w[msa_pkg::ST_BULK_OVF] = bulk_ovf_q;
    status_w[msa_pkg::ST_GO] = go_s[1];
  end

  // Address phase is captured; reads are answered in the next cycle.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      ap_wr_q <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
      ap_addr_q <= haddr_in[7:0];
      rdata_q <= 32'h0000_0000;
      if (hsel_in && htrans_in[1] && hready_in && !hwrite_in) begin
        case (haddr_in[7:0])
          msa_pkg::REG_CTRL: rdata_q <= {ctrl_q[31:2], 2'h0};
          msa_pkg::REG_STATUS: rdata_q <= status_w;
          msa_pkg::REG_RANGE: rdata_q <= range_q;
          msa_pkg::REG_DELAY: rdata_q <= delay_q;
          msa_pkg::REG_HOLDOFF: rdata_q <= holdoff_q;
          msa_pkg::REG_PRESET: rdata_q <= preset_q;
          msa_pkg::REG_SWEEPS: rdata_q <= sweep_q;
          msa_pkg::REG_IO_MODE: rdata_q <= {16'h0000, io_mode_q};
          msa_pkg::REG_IO_OUT: rdata_q <= {24'h000000, io_val_q};
          msa_pkg::REG_IO_IN: rdata_q <= {24'h000000, io_s2};
          msa_pkg::REG_TAP_SEL: rdata_q <= {27'h0, tap_sel_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Settings registers; start and halt bits are write pulses.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= msa_pkg::CTRL_RESET;
      range_q <= 32'h0000_0000;
      delay_q <= 32'h0000_0000;
      holdoff_q <= 32'h0000_0000;
      preset_q <= 32'h0000_0000;
      io_mode_q <= 16'h0000;
      io_val_q <= 8'h00;
      tap_sel_q <= 5'h00;
    end else begin
      ctrl_q.start <= 1'b0;
      ctrl_q.halt <= 1'b0;
      if (wr_en) begin
        case (ap_addr_q)
          msa_pkg::REG_CTRL: ctrl_q <= hwdata_in;
          msa_pkg::REG_RANGE: range_q <= hwdata_in;
          msa_pkg::REG_DELAY: delay_q <= hwdata_in;
          msa_pkg::REG_HOLDOFF: holdoff_q <= hwdata_in;
          msa_pkg::REG_PRESET: preset_q <= hwdata_in;
          msa_pkg::REG_IO_MODE: io_mode_q <= hwdata_in[15:0];
          msa_pkg::REG_IO_OUT: io_val_q <= hwdata_in[7:0];
          msa_pkg::REG_TAP_SEL: tap_sel_q <= hwdata_in[4:0];
          default: ;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // Run/halt line
  // -------------------------------------------------------------------
  assign go_low = ctrl_q.go_watch && !go_s[1] && (run_sr_q[2] || !run_q);
  assign halt = ctrl_q.halt || go_low;

  // Open drain: the pin is only ever pulled low, never driven high.
  assign go_out = 1'b0;
  always_comb begin
    if (ctrl_q.go_force_en) begin
      go_oe_out = !ctrl_q.go_force_val;
    end else begin
      go_oe_out = ctrl_q.go_drive && !run_q;
    end
  end

  // Run flag follows software start and any halt.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q <= 1'b0;
    end else if (halt) begin
      run_q <= 1'b0;
    end else if (ctrl_q.start) begin
      run_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Digital I/O port
  // -------------------------------------------------------------------
  // Mode 0 input only, 1 open-drain pull-down, 2 or 3 driven.
  for (genvar i = 0; i < 8; i++) begin : g_io
    assign io_out[i] = io_mode_q[2*i+1] ? io_val_q[i] : 1'b0;
    assign io_oe_out[i] = io_mode_q[2*i+1] ||
      (io_mode_q[2*i] && !io_val_q[i]);
  end

  // -------------------------------------------------------------------
  // Sweep sequencer
  // -------------------------------------------------------------------
  assign active = st_q == SWEEP;
  assign sweep_init = ctrl_q.preset_en ?
    msa_pkg::SWEEP_FULL - preset_q : 32'h0000_0000;
  assign can_start = !(ctrl_q.preset_en &&
    sweep_q == msa_pkg::SWEEP_FULL);
  assign accept_trg = trig && st_q == ARMED && can_start &&
    hold_q[37:msa_pkg::TICK_LSB] >= holdoff_q;
  assign sweep_end = ctrl_q.mode != msa_pkg::MODE_CONT &&
    timer_q[37:msa_pkg::TICK_LSB] >= range_q;
  assign in_window = timer_q[37:msa_pkg::TICK_LSB] >= delay_q &&
    (ctrl_q.mode == msa_pkg::MODE_CONT ||
    timer_q[37:msa_pkg::TICK_LSB] < range_q);

  // State walk: armed, sweep, dead time, and drain in sequential mode.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= IDLE;
      dead_q <= 8'h00;
      seq_q <= 1'b0;
    end else begin
      seq_q <= 1'b0;
      if (!run_q || halt) begin
        st_q <= IDLE;
      end else begin
        case (st_q)
          IDLE: begin
            // Continuous mode may start straight from software.
            st_q <= ctrl_q.mode == msa_pkg::MODE_CONT && can_start ?
              SWEEP : ARMED;
          end
          ARMED: if (accept_trg) begin
            st_q <= SWEEP;
          end
          SWEEP: if (sweep_end) begin
            st_q <= DEAD;
            dead_q <= 8'(msa_pkg::DEAD_CYC - 1);
          end
          DEAD: begin
            if (dead_q != 8'h00) begin
              dead_q <= dead_q - 8'h01;
            end else if (ctrl_q.mode == msa_pkg::MODE_SEQ && !can_start) begin
              st_q <= DRAIN;
            end else begin
              st_q <= ARMED;
            end
          end
          DRAIN: if (f_empty && !out_v_q && b_empty) begin
            st_q <= ARMED;
            seq_q <= 1'b1;
          end
          default: st_q <= IDLE;
        endcase
      end
    end
  end
  assign seq_done_out = seq_q;

  // Sweep counter: loaded at run start and at each sequence close.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sweep_q <= 32'h0000_0000;
    end else if (ctrl_q.start && !run_q) begin
      sweep_q <= sweep_init;
    end else if (st_q == DRAIN && seq_q == 1'b0 &&
      f_empty && !out_v_q && b_empty) begin
      sweep_q <= sweep_init;
    end else if (accept_trg ||
      (st_q == IDLE && run_q && !halt &&
      ctrl_q.mode == msa_pkg::MODE_CONT && can_start)) begin
      sweep_q <= sweep_q + 32'h0000_0001;
    end
  end

  // Timer counts bins while sweeping and restarts at each sweep.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_q <= 38'h0;
    end else if (st_q != SWEEP) begin
      timer_q <= 38'h0;
    end else begin
      timer_q <= timer_q + msa_pkg::TIMER_STEP;
    end
  end

  // Hold-off time since the last accepted trigger, saturating.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_q <= 38'h0;
    end else if (accept_trg) begin
      hold_q <= 38'h0;
    end else if (hold_q[37] == 1'b0) begin
      hold_q <= hold_q + msa_pkg::TIMER_STEP;
    end
  end

  // Taps: timer bits 5..31, active only while a sweep runs.
  assign tap_out = active ? timer_q[31:5] : 27'h0;
  assign sync_out = tap_sel_q < 5'h1b ? tap_out[tap_sel_q] : 1'b0;
  assign sweep_active_out = active;

  // -------------------------------------------------------------------
  // Stop pipeline and tag sampling
  // -------------------------------------------------------------------
  // Stops and markers travel the line so tags are caught later.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < msa_pkg::TAG_DLY_CYC; i++) begin
        dly_q[i] <= '0;
      end
    end else begin
      dly_q[0].valid <= (active && stop_ev && in_window) ||
        (accept_trg && ctrl_q.marker_en);
      dly_q[0].marker <= accept_trg;
      dly_q[0].stamp <= timer_q[31:0];
      for (int i = 1; i < msa_pkg::TAG_DLY_CYC; i++) begin
        dly_q[i] <= dly_q[i-1];
      end
    end
  end

  // Event word with tags taking the top byte when enabled.
  always_comb begin
    ev_word = dly_q[msa_pkg::TAG_DLY_CYC-1].stamp;
    if (dly_q[msa_pkg::TAG_DLY_CYC-1].marker) begin
      ev_word = msa_pkg::MARKER_WORD;
    end else if (ctrl_q.tag_en) begin
      ev_word[31:24] = tag_s2;
    end
  end

  // -------------------------------------------------------------------
  // First buffer
  // -------------------------------------------------------------------
  assign f_full = f_cnt_q == 8'(msa_pkg::FAST_DEPTH);
  assign f_empty = f_cnt_q == 8'h00;
  assign f_push = dly_q[msa_pkg::TAG_DLY_CYC-1].valid;
  assign fwd = !f_empty && !b_full;
  assign f_word = fast_mem[f_rd_q];

  // Writes drop while full; stored entries are left intact.
  always_ff @(posedge clk_in) begin
    if (f_push && !f_full) begin
      fast_mem[f_wr_q] <= ev_word;
    end
  end

  // Pointers wrap at the depth; fill counts pushes minus forwards.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      f_wr_q <= 7'h00;
      f_rd_q <= 7'h00;
      f_cnt_q <= 8'h00;
    end else begin
      if (f_push && !f_full) begin
        f_wr_q <= f_wr_q == 7'(msa_pkg::FAST_DEPTH - 1) ?
          7'h00 : f_wr_q + 7'h01;
      end
      if (fwd) begin
        f_rd_q <= f_rd_q == 7'(msa_pkg::FAST_DEPTH - 1) ?
          7'h00 : f_rd_q + 7'h01;
      end
      f_cnt_q <= f_cnt_q + 8'(f_push && !f_full) - 8'(fwd);
    end
  end

  // -------------------------------------------------------------------
  // Second buffer and host stream
  // -------------------------------------------------------------------
  assign b_full = b_cnt_q == 15'(msa_pkg::BULK_DEPTH);
  assign b_empty = b_cnt_q == 15'h0;
  assign b_pop = !b_empty && (!out_v_q || evt_ready_in);

  // Forwarded words land in the large buffer.
  always_ff @(posedge clk_in) begin
    if (fwd) begin
      bulk_mem[b_wr_q] <= f_word;
    end
  end

  // Bulk pointers and the registered output stage.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      b_wr_q <= 14'h0;
      b_rd_q <= 14'h0;
      b_cnt_q <= 15'h0;
      out_q <= 32'h0000_0000;
      out_v_q <= 1'b0;
    end else begin
      if (fwd) begin
        b_wr_q <= b_wr_q + 14'h1;
      end
      if (b_pop) begin
        b_rd_q <= b_rd_q + 14'h1;
        out_q <= bulk_mem[b_rd_q];
        out_v_q <= 1'b1;
      end else if (evt_ready_in) begin
        out_v_q <= 1'b0;
      end
      b_cnt_q <= b_cnt_q + 15'(fwd) - 15'(b_pop);
    end
  end
  assign evt_data_out = out_q;
  assign evt_valid_out = out_v_q;
  assign fast_buffer_full_out = f_full;
  assign bulk_buffer_full_out = b_full;

  // Sticky overflow flags: a new overflow wins over a clear.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_ovf_q <= 1'b0;
      bulk_ovf_q <= 1'b0;
    end else begin
      if (f_push && f_full) begin
        fast_ovf_q <= 1'b1;
      end else if (wr_status && hwdata_in[msa_pkg::ST_FAST_OVF]) begin
        fast_ovf_q <= 1'b0;
      end
      if (!f_empty && b_full) begin
        bulk_ovf_q <= 1'b1;
      end else if (wr_status && hwdata_in[msa_pkg::ST_BULK_OVF]) begin
        bulk_ovf_q <= 1'b0;
      end
    end
  end

endmodule // msa_top

// [shared/msa_pkg.sv]
package msa_pkg;

  // -------------------------------------------------------------------
  // Register map (byte addresses)
  // -------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RANGE = 8'h08;
  localparam logic [7:0] REG_DELAY = 8'h0c;
  localparam logic [7:0] REG_HOLDOFF = 8'h10;
  localparam logic [7:0] REG_PRESET = 8'h14;
  localparam logic [7:0] REG_SWEEPS = 8'h18;
  localparam logic [7:0] REG_IO_MODE = 8'h1c;
  localparam logic [7:0] REG_IO_OUT = 8'h20;
  localparam logic [7:0] REG_IO_IN = 8'h24;
  localparam logic [7:0] REG_TAP_SEL = 8'h28;

  // Status bit positions; bits 4 and 5 are sticky, write one clears.
  localparam int ST_RUN = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_FAST_FULL = 2;
  localparam int ST_BULK_FULL = 3;
  localparam int ST_FAST_OVF = 4;
  localparam int ST_BULK_OVF = 5;
  localparam int ST_GO = 6;
  // Acquisition modes.
  localparam logic [1:0] MODE_SAS = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_SEQ = 2'h2;

  // Control register layout, high bits first.
  typedef struct packed {
    logic [20:0] rsvd;
    logic [1:0] mode;
    logic preset_en;
    logic tag_en;
    logic marker_en;
    logic go_force_val;
    logic go_force_en;
    logic go_drive;
    logic go_watch;
    logic halt;
    logic start;
  } msa_ctrl_t;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // One entry of the stop pipeline.
  typedef struct packed {
    logic valid;
    logic marker;
    logic [31:0] stamp;
  } msa_evt_t;

  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_PS = 5000;
  localparam int BIN_PS = 250;
  localparam logic [37:0] TIMER_STEP = 38'(CLK_PS / BIN_PS);
  localparam int DEAD_NS = 200;
  localparam int DEAD_CYC = (DEAD_NS * 1000) / CLK_PS;
  localparam int TAG_DLY_NS = 112;
  localparam int TAG_DLY_CYC = (TAG_DLY_NS * 1000 + CLK_PS / 2) / CLK_PS;
  localparam int TICK_LSB = 6;

  // Buffers and words.
  localparam int FAST_DEPTH = 127;
  localparam int BULK_DEPTH = 16384;
  localparam logic [31:0] MARKER_WORD = 32'hffff_ffff;
  localparam logic [31:0] SWEEP_FULL = 32'hffff_ffff;

endpackage

// [tb/msa_partner.sv]
`timescale 1ns/1ps

// -------------------------------------------------------------------
// Detector pulses, shared run line and list data sink.
// -------------------------------------------------------------------
module msa_partner (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_oe_in,
  input wire logic [31:0] evt_data_in,
  input wire logic evt_valid_in,
  output logic evt_ready_out,
  output logic trigger_out = 1'b0,
  output logic stop_out = 1'b0,
  output logic [7:0] tag_out = 8'h00,
  output logic go_level_out
);
  logic slow_q = 1'b0; // Sink stalls four cycles in eight when set.
  logic pull_q = 1'b0; // Another device pulls the run line low.
  logic [2:0] tick_q; // Stall pattern counter.
  logic [31:0] got [$]; // Words taken from the core.
  // The run line is wired-AND with a pull-up.
  assign go_level_out = !go_oe_in && !pull_q;
  assign evt_ready_out = !slow_q || tick_q[2];
  // Free running stall counter.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) tick_q <= 3'h0;
    else tick_q <= tick_q + 3'h1;
  end
  // Words move at an edge with valid and ready both high.
  always @(posedge clk_in) begin
    if (evt_valid_in === 1'b1 && evt_ready_out) got.push_back(evt_data_in);
  end
  // Trigger pulse, then stops s1, s2, s3 cycles later; tags held steady.
  task shoot(input int s1, input int s2, input int s3);
    for (int i = 0; i <= s3 + 2; i++) begin
      @(posedge clk_in);
      trigger_out <= (i < 2);
      stop_out <= (i >= s1 && i < s1 + 2) || (i >= s2 && i < s2 + 2)
        || (i >= s3 && i < s3 + 2);
    end
  endtask
endmodule // msa_partner

// [tb/msa_top_monitor.sv]
`timescale 1ns/1ps

// -------------------------------------------------------------------
// Port checker for the acquisition core.
// -------------------------------------------------------------------
module msa_top_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic go_out,
  input wire logic [26:0] tap_out,
  input wire logic sweep_active_out,
  input wire logic seq_done_out,
  input wire logic [31:0] evt_data_out,
  input wire logic evt_valid_out,
  input wire logic evt_ready_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // A word offered but not taken.
  sequence s_stall; evt_valid_out && !evt_ready_in; endsequence
  // Three cycles of a running sweep.
  sequence s_run3; sweep_active_out [*3]; endsequence
  okay_resp_a: assert property (hreadyout_out && !hresp_out)
    else $error("slave stalled or answered with an error");
  rdata_idle_a: assert property (
    !(hsel_in && htrans_in[1] && hready_in && !hwrite_in)
    |=> hrdata_out == 32'h0) else $error("read data outside a read");
  go_low_a: assert property (go_out == 1'b0)
    else $error("run line driven high");
  seq_pulse_a: assert property (seq_done_out |=> !seq_done_out)
    else $error("sequence end longer than one cycle");
  seq_idle_a: assert property (seq_done_out |-> !sweep_active_out)
    else $error("sequence closed during a sweep");
  evt_hold_a: assert property (
    s_stall |=> evt_valid_out && $stable(evt_data_out))
    else $error("event word changed before it was taken");
  tap_idle_a: assert property (
    !sweep_active_out && !$past(sweep_active_out) |-> tap_out == 27'h0)
    else $error("timer taps move outside a sweep");
  tap_run_a: assert property (s_run3 |-> tap_out != $past(tap_out, 2))
    else $error("timer taps frozen in a sweep");
endmodule // msa_top_monitor

bind msa_top msa_top_monitor msa_top_monitor_inst (.clk_in, .rst_in,
  .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out,
  .hreadyout_out, .hresp_out, .go_out, .tap_out, .sweep_active_out,
  .seq_done_out, .evt_data_out, .evt_valid_out, .evt_ready_in);

// [tb/multiscaler_sweep_acquisition_test.sv]
`timescale 1ns/1ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end

// -------------------------------------------------------------------
// Register tests through AHB-Lite against modelled detector pulses.
// -------------------------------------------------------------------
module multiscaler_sweep_acquisition_test;
  logic clk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, evt_data_out;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2; // Whole words only.
  logic hready_in, hreadyout_out, hresp_out, trigger_in, stop_in, go_in;
  logic go_out, go_oe_out, sync_out, sweep_active_out, fast_buffer_full_out;
  logic bulk_buffer_full_out, seq_done_out, evt_valid_out, evt_ready_in;
  logic act_d = 1'b0;
  logic [7:0] tag_in, io_in, io_out, io_oe_out;
  logic [26:0] tap_out;
  int failures = 0, checks_done = 0, starts = 0, seq_seen = 0, cycles = 0;
  always #2.5 clk_in = !clk_in;
  assign hready_in = hreadyout_out;
  // Undriven I/O pins float high through pull-ups.
  assign io_in = (io_oe_out & io_out) | ~io_oe_out;
  msa_top msa_top_inst (.clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out,
    .hreadyout_out, .hresp_out, .trigger_in, .stop_in, .tag_in, .go_in,
    .go_out, .go_oe_out, .io_in, .io_out, .io_oe_out, .tap_out, .sync_out,
    .sweep_active_out, .fast_buffer_full_out, .bulk_buffer_full_out,
    .seq_done_out, .evt_data_out, .evt_valid_out, .evt_ready_in);
  msa_partner msa_partner_inst (.clk_in, .rst_in, .go_oe_in(go_oe_out),
    .evt_data_in(evt_data_out), .evt_valid_in(evt_valid_out),
    .evt_ready_out(evt_ready_in), .trigger_out(trigger_in),
    .stop_out(stop_in), .tag_out(tag_in), .go_level_out(go_in));
  // Counts sweep starts, closed sequences and cycles; cuts hangs short.
  always @(posedge clk_in) begin
    starts += (sweep_active_out === 1'b1 && act_d !== 1'b1);
    seq_seen += (seq_done_out === 1'b1);
    act_d <= sweep_active_out;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict;
    end
  end
  // One single transfer: address phase, then data phase.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel_in <= 1'b1; htrans_in <= 2'h2; haddr_in <= {24'h0, a};
    hwrite_in <= w;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    rd = hrdata_out;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask
  // Waits for the sweep to end, then lets buffers drain.
  task settle(input int n);
    repeat (300) if (sweep_active_out !== 1'b0) @(posedge clk_in);
    repeat (n) @(posedge clk_in);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(msa_pkg::REG_CTRL, d); `CHK(d, msa_pkg::CTRL_RESET)
    rd(msa_pkg::REG_STATUS, d); `CHK(d, 32'h40)
    rd(msa_pkg::REG_SWEEPS, d); `CHK(d, 32'h0)
    rd(8'h3c, d); `CHK(d, 32'h0)
    wr(msa_pkg::REG_RANGE, 32'h4);
    wr(msa_pkg::REG_DELAY, 32'h1);
    wr(msa_pkg::REG_HOLDOFF, 32'h0);
    wr(msa_pkg::REG_CTRL, 32'h41);
    msa_partner_inst.shoot(1, 6, 20);
    settle(40);
    `CHK(msa_partner_inst.got.size(), 2)
    `CHK(msa_partner_inst.got[0], msa_pkg::MARKER_WORD)
    `CHK(msa_partner_inst.got[1] inside {[32'h50:32'h8c]}, 1'b1)
    rd(msa_pkg::REG_SWEEPS, d); `CHK(d, 32'h1)
    wr(msa_pkg::REG_CTRL, 32'hc0);
    msa_partner_inst.tag_out <= 8'ha5;
    msa_partner_inst.slow_q <= 1'b1;
    msa_partner_inst.shoot(1, 6, 20);
    settle(60);
    `CHK(starts, 2)
    `CHK(msa_partner_inst.got[2], msa_pkg::MARKER_WORD)
    `CHK(msa_partner_inst.got[3][31:24], 8'ha5)
    rd(msa_pkg::REG_SWEEPS, d); `CHK(d, 32'h2)
    wr(msa_pkg::REG_CTRL, 32'h2);
    wr(msa_pkg::REG_PRESET, 32'h1);
    wr(msa_pkg::REG_CTRL, 32'h101);
    repeat (2) begin
      msa_partner_inst.shoot(1, 6, 20);
      settle(45);
    end
    `CHK(starts, 3)
    rd(msa_pkg::REG_SWEEPS, d); `CHK(d, 32'hffffffff)
    wr(msa_pkg::REG_CTRL, 32'h2);
    wr(msa_pkg::REG_CTRL, 32'h501);
    msa_partner_inst.shoot(1, 6, 20);
    settle(150);
    `CHK(seq_seen, 1)
    rd(msa_pkg::REG_SWEEPS, d); `CHK(d, 32'hfffffffe)
    wr(msa_pkg::REG_CTRL, 32'h2);
    wr(msa_pkg::REG_CTRL, 32'h20d);
    repeat (4) @(posedge clk_in);
    `CHK(sweep_active_out, 1'b1)
    `CHK(go_oe_out, 1'b0)
    msa_partner_inst.pull_q <= 1'b1;
    repeat (8) @(posedge clk_in);
    `CHK(sweep_active_out, 1'b0)
    `CHK(go_oe_out, 1'b1)
    msa_partner_inst.pull_q <= 1'b0;
    wr(msa_pkg::REG_CTRL, 32'h30);
    repeat (2) @(posedge clk_in);
    `CHK(go_oe_out, 1'b0)
    wr(msa_pkg::REG_CTRL, 32'h10);
    repeat (2) @(posedge clk_in);
    `CHK(go_oe_out, 1'b1)
    wr(msa_pkg::REG_IO_MODE, 32'h9);
    wr(msa_pkg::REG_IO_OUT, 32'h2);
    repeat (4) @(posedge clk_in);
    `CHK(io_oe_out, 8'h03)
    `CHK(io_out[1], 1'b1)
    rd(msa_pkg::REG_IO_IN, d); `CHK(d, 32'hfe)
    print_verdict;
  end
endmodule // multiscaler_sweep_acquisition_test
